// *** rtl/usb_ep_device.sv ***
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module usb_ep_device import usb_ep_pkg::*; #(
	parameter int MPS_BITS = 11
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_B,
	// link to the controller
	usb_ep_if.dev            LINK,
	// user side status
	output logic             EP0_OUT_TOGGLE,
	output logic             SETUP_RECEIVED,
	output logic [10:0]      EPA_MAX_PACKET,
	output logic             EPA_DIR_IN,
	output logic             EPA_TOGGLE
);

	// ======================================================================
	// elaboration check
	if (MPS_BITS < 9 || MPS_BITS > 11)
	begin : g_bad_mps
		$error("MPS_BITS must lie between 9 and 11");
	end

	// ======================================================================
	// state
	logic                auto_nak_q;
	logic                tog0_q;
	logic                tog0_d;
	logic                nak_q;
	logic                nak_d;
	logic                nak_pend_q;
	logic                nak_pend_d;
	logic                stall_q;
	logic                stall_d;
	logic                setup_q;
	logic                setup_d;
	logic [MPS_BITS-1:0] mps_q;
	logic                dir_in_q;
	logic                intm_q;
	logic                iso_q;
	logic [3:0]          epnum_q;
	logic                toga_q;
	logic                toga_d;
	logic                busy_q;
	kind_e               kind_q;
	logic                hit0_q;
	logic                hita_q;
	logic                pid_q;
	resp_e               resp_q;
	logic [7:0]          rdata_q;
	logic                rv_q;

	// ======================================================================
	// register decode
	wire logic [7:0] wd     = LINK.reg_wdata;
	wire logic       wr_ctl = LINK.reg_wr && (LINK.reg_addr == OFF_EP0_OUT_CTRL);
	wire logic       wr_hi  = LINK.reg_wr && (LINK.reg_addr == OFF_EPA_MPS_HI);
	wire logic       wr_lo  = LINK.reg_wr && (LINK.reg_addr == OFF_EPA_MPS_LO);
	wire logic       wr_cfg = LINK.reg_wr && (LINK.reg_addr == OFF_EPA_CFG);
	wire logic       wr_evt = LINK.reg_wr && (LINK.reg_addr == OFF_DEV_EVENT);
	wire logic [10:0] mps11 = 11'(mps_q);

	// read mux; reserved and unmapped bits read zero
	wire logic [7:0] rd_ctl = {auto_nak_q, 2'b00, tog0_q, 2'b00, nak_q, stall_q};
	wire logic [7:0] rd_hi  = {5'h00, mps11[10:8]};
	wire logic [7:0] rd_lo  = mps11[7:0];
	wire logic [7:0] rd_cfg = {dir_in_q, intm_q, iso_q, 1'b0, epnum_q};
	wire logic [7:0] rd_evt = {7'h00, setup_q};
	wire logic [7:0] rd_mux =
		(LINK.reg_addr == OFF_EP0_OUT_CTRL) ? rd_ctl :
		(LINK.reg_addr == OFF_EPA_MPS_HI)   ? rd_hi  :
		(LINK.reg_addr == OFF_EPA_MPS_LO)   ? rd_lo  :
		(LINK.reg_addr == OFF_EPA_CFG)      ? rd_cfg :
		(LINK.reg_addr == OFF_DEV_EVENT)    ? rd_evt : 8'h00;

	// ======================================================================
	// answer chosen when the token arrives, so later writes cannot change it
	wire logic  is_out  = (LINK.tx_kind == KIND_OUT);
	wire logic  is_ping = (LINK.tx_kind == KIND_PING);
	wire logic  is_in   = (LINK.tx_kind == KIND_IN);
	wire logic  hit0    = (LINK.tx_ep == 4'h0);
	// endpoint number zero never matches endpoint A
	wire logic  dir_ok  = dir_in_q ? is_in : (is_out || is_ping);
	wire logic  hita    = !hit0 && (LINK.tx_ep == epnum_q) && dir_ok;

	// control endpoint: stall beats nak beats ack; IN side lives elsewhere
	wire resp_e resp0 =
		(LINK.tx_kind == KIND_SETUP) ? RESP_ACK :
		!(is_out || is_ping)         ? RESP_NONE :
		stall_q                      ? RESP_STALL :
		nak_q                        ? RESP_NAK : RESP_ACK;

	// endpoint A: iso has no handshake, oversize OUT is dropped
	wire resp_e respa =
		iso_q                           ? RESP_NONE :
		is_ping                         ? (intm_q ? RESP_NONE : RESP_ACK) :
		(is_out && LINK.tx_len > mps11) ? RESP_NONE : RESP_ACK;

	wire resp_e resp_start = hit0 ? resp0 : (hita ? respa : RESP_NONE);

	// ======================================================================
	// completion events
	wire logic ended      = LINK.tx_end && busy_q;
	wire logic end_ok     = ended && !LINK.tx_err;
	wire logic setup_done = end_ok && hit0_q && (kind_q == KIND_SETUP);
	wire logic out0_take  = end_ok && hit0_q && (kind_q == KIND_OUT)
	                        && (resp_q == RESP_ACK) && (pid_q == tog0_q);
	// always-toggle IN flips whatever the outcome; otherwise only on success
	wire logic a_norm     = end_ok && (resp_q == RESP_ACK)
	                        && ((kind_q == KIND_IN) || ((kind_q == KIND_OUT) && (pid_q == toga_q)));
	wire logic a_flip     = ended && hita_q && !iso_q
	                        && (((kind_q == KIND_IN) && intm_q) || a_norm);

	// ======================================================================
	// control endpoint OUT toggle
	always_comb
	begin
		tog0_d = tog0_q;
		if (out0_take)
			tog0_d = ~tog0_q;
		if (setup_done)
			tog0_d = 1'b1; // data stage after setup starts at one
		if (wr_ctl && wd[B_TOG_ONE])
			tog0_d = 1'b1;
		if (wr_ctl && wd[B_TOG_ZERO])
			tog0_d = 1'b0;
	end

	// nak_hold: hardware sets win over a software clear in the same cycle
	always_comb
	begin
		nak_d      = nak_q;
		nak_pend_d = nak_pend_q;
		if (wr_ctl && wd[B_NAK_HOLD])
		begin
			if (busy_q && !LINK.tx_end)
				nak_pend_d = 1'b1;
			else
				nak_d = 1'b1;
		end
		else if (wr_ctl && !setup_q)
		begin
			nak_d      = 1'b0;
			nak_pend_d = 1'b0;
		end
		if (ended && nak_pend_q)
		begin
			nak_d      = 1'b1;
			nak_pend_d = 1'b0;
		end
		if (out0_take && auto_nak_q)
			nak_d = 1'b1;
		if (setup_done)
			nak_d = 1'b1;
	end

	// stall_hold, setup flag and endpoint A toggle
	always_comb
	begin
		stall_d = stall_q;
		if (wr_ctl && !wd[B_STALL_HOLD])
			stall_d = 1'b0;
		else if (wr_ctl && !setup_q)
			stall_d = 1'b1;
		if (setup_done)
			stall_d = 1'b0;
		setup_d = setup_q;
		if (wr_evt && wd[B_SETUP_FLAG])
			setup_d = 1'b0;
		if (setup_done)
			setup_d = 1'b1; // a new setup beats its own clear
		toga_d = toga_q;
		if (a_flip)
			toga_d = ~toga_q;
		if (wr_cfg)
			toga_d = 1'b0; // reconfiguring restarts the sequence
	end

	// ======================================================================
	// control endpoint registers and the endpoint A toggle
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			auto_nak_q <= RST_EP0_OUT_CTRL[B_AUTO_NAK];
			tog0_q     <= RST_EP0_OUT_CTRL[B_TOGGLE];
			nak_q      <= RST_EP0_OUT_CTRL[B_NAK_HOLD];
			stall_q    <= RST_EP0_OUT_CTRL[B_STALL_HOLD];
			nak_pend_q <= 1'b0;
			setup_q    <= 1'b0;
			toga_q     <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
				auto_nak_q <= wd[B_AUTO_NAK];
			tog0_q     <= tog0_d;
			nak_q      <= nak_d;
			stall_q    <= stall_d;
			nak_pend_q <= nak_pend_d;
			setup_q    <= setup_d;
			toga_q     <= toga_d;
		end
	end

	// endpoint A configuration
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			mps_q    <= MPS_BITS'(RST_EPA_MPS);
			dir_in_q <= RST_EPA_CFG[B_DIR_IN];
			intm_q   <= RST_EPA_CFG[B_INT_MODE];
			iso_q    <= RST_EPA_CFG[B_ISO];
			epnum_q  <= RST_EPA_CFG[EPNUM_MSB:0];
		end
		else
		begin
			if (wr_hi)
				mps_q <= MPS_BITS'({wd[MPS_HI_MSB:0], mps11[7:0]});
			if (wr_lo)
				mps_q <= MPS_BITS'({mps11[10:8], wd});
			if (wr_cfg)
			begin
				dir_in_q <= wd[B_DIR_IN];
				intm_q   <= wd[B_INT_MODE];
				iso_q    <= wd[B_ISO];
				epnum_q  <= wd[EPNUM_MSB:0];
			end
		end
	end

	// ======================================================================
	// transaction tracking and answers
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			busy_q  <= 1'b0;
			kind_q  <= KIND_OUT;
			hit0_q  <= 1'b0;
			hita_q  <= 1'b0;
			pid_q   <= 1'b0;
			resp_q  <= RESP_NONE;
			rv_q    <= 1'b0;
			rdata_q <= 8'h00;
		end
		else
		begin
			rv_q <= LINK.tx_start;
			if (LINK.tx_start)
			begin
				busy_q <= 1'b1;
				kind_q <= LINK.tx_kind;
				hit0_q <= hit0;
				hita_q <= hita;
				pid_q  <= LINK.tx_pid;
				resp_q <= resp_start;
			end
			else if (LINK.tx_end)
				busy_q <= 1'b0;
			if (LINK.reg_rd)
				rdata_q <= rd_mux;
		end
	end

	// ======================================================================
	// outputs
	assign LINK.reg_rdata  = rdata_q;
	assign LINK.resp_valid = rv_q;
	assign LINK.resp_code  = resp_q;
	assign EP0_OUT_TOGGLE  = tog0_q;
	assign SETUP_RECEIVED  = setup_q;
	assign EPA_MAX_PACKET  = mps11;
	assign EPA_DIR_IN      = dir_in_q;
	assign EPA_TOGGLE      = toga_q;

endmodule

// *** rtl/usb_ep_pkg.sv ***
// ==========================================================================
// shared constants for the endpoint control block and its controller
package usb_ep_pkg;

	// ======================================================================
	// device register offsets (device's own register port)
	localparam logic [7:0] OFF_EP0_OUT_CTRL = 8'hF3;
	localparam logic [7:0] OFF_EPA_MPS_HI   = 8'hF8;
	localparam logic [7:0] OFF_EPA_MPS_LO   = 8'hF9;
	localparam logic [7:0] OFF_EPA_CFG      = 8'hFA;
	localparam logic [7:0] OFF_DEV_EVENT    = 8'h20;

	// control endpoint OUT control fields
	localparam int B_AUTO_NAK   = 7;
	localparam int B_TOGGLE     = 4;
	localparam int B_TOG_ONE    = 3;
	localparam int B_TOG_ZERO   = 2;
	localparam int B_NAK_HOLD   = 1;
	localparam int B_STALL_HOLD = 0;

	// endpoint A configuration fields
	localparam int B_DIR_IN     = 7;
	localparam int B_INT_MODE   = 6;
	localparam int B_ISO        = 5;
	localparam int EPNUM_MSB    = 3;
	localparam int MPS_HI_MSB   = 2;

	// device event status fields
	localparam int B_SETUP_FLAG = 0;

	// reset values
	localparam logic [7:0]  RST_EP0_OUT_CTRL = 8'h00;
	localparam logic [7:0]  RST_EPA_CFG      = 8'h00;
	localparam logic [10:0] RST_EPA_MPS      = 11'h000;

	// maximum packet size limits
	localparam logic [10:0] MPS_INT_FS  = 11'h040;
	localparam logic [10:0] MPS_INT_HS  = 11'h200;
	localparam logic [10:0] MPS_BULK_HS = 11'h200;
	localparam logic [10:0] MPS_ISO_FS  = 11'h3FF;
	localparam logic [10:0] MPS_ISO_HS  = 11'h400;

	// ======================================================================
	// controller register offsets on the AHB-Lite bus
	localparam logic [7:0] A_CMD    = 8'h00;
	localparam logic [7:0] A_TXN    = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_CTRL   = 8'h0C;

	// command word and transaction word fields
	localparam int C_ADDR_LSB = 8;
	localparam int C_DATA_LSB = 16;
	localparam int T_KIND_LSB = 4;
	localparam int T_PID      = 6;
	localparam int T_ERR      = 7;
	localparam int T_LEN_LSB  = 16;

	// status word fields
	localparam int S_BUSY     = 0;
	localparam int S_RESP_LSB = 1;
	localparam int S_REFUSED  = 3;
	localparam int S_RD_LSB   = 8;

	// ======================================================================
	// enumerations
	typedef enum logic [1:0] {KIND_OUT, KIND_IN, KIND_SETUP, KIND_PING} kind_e;
	typedef enum logic [1:0] {RESP_NONE, RESP_ACK, RESP_NAK, RESP_STALL} resp_e;
	typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ} op_e;

endpackage

// *** rtl/usb_ep_if.sv ***
`timescale 1ns/10ps
// ==========================================================================
// link between the endpoint control block and its controller
interface usb_ep_if import usb_ep_pkg::*; ();
	// register port
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	// transaction events
	logic        tx_start;
	kind_e       tx_kind;
	logic [3:0]  tx_ep;
	logic        tx_pid;
	logic [10:0] tx_len;
	logic        tx_end;
	logic        tx_err;
	// handshake answer
	logic        resp_valid;
	resp_e       resp_code;

	modport dev (
		input  reg_wr, reg_rd, reg_addr, reg_wdata,
		input  tx_start, tx_kind, tx_ep, tx_pid, tx_len, tx_end, tx_err,
		output reg_rdata, resp_valid, resp_code
	);

	modport ctl (
		output reg_wr, reg_rd, reg_addr, reg_wdata,
		output tx_start, tx_kind, tx_ep, tx_pid, tx_len, tx_end, tx_err,
		input  reg_rdata, resp_valid, resp_code
	);
endinterface

// *** rtl/usb_ep_controller.sv ***
`timescale 1ns/10ps
// ==========================================================================
// controller end: software orders arrive over AHB-Lite and are played
// onto the link as register accesses and transactions
module usb_ep_controller import usb_ep_pkg::*; #(
	parameter int TXN_CYCLES = 4
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_B,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// link to the device
	usb_ep_if.ctl            LINK
);

	// ======================================================================
	if (TXN_CYCLES < 1 || TXN_CYCLES > 256)
	begin : g_bad_txn
		$error("TXN_CYCLES must lie between 1 and 256");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_DONE, ST_RD, ST_RDCAP, ST_TXN} state_e;

	state_e      st_q, st_d;
	logic [7:0]  cnt_q, cnt_d;
	logic        dp_wr_q;
	logic [7:0]  dp_addr_q;
	logic [31:0] hrdata_q;
	logic        hs_q;
	logic        refused_q;
	resp_e       resp_q;
	logic [7:0]  rdv_q;
	logic        sh_iso_q, sh_intm_q, sh_dir_q;
	logic [2:0]  sh_hi_q;
	logic        wr_q, rd_q, start_q, end_q;
	logic        wr_d, rd_d, start_d, end_d;
	logic [7:0]  addr_q, wdata_q;
	kind_e       kind_q;
	logic [3:0]  ep_q;
	logic        pid_q, err_q;
	logic [10:0] len_q;

	// size legality as software must keep it
	function automatic logic legal_mps(input logic [10:0] m, input logic iso,
	                                   input logic bulk, input logic hs);
		if (iso)
			return (m != 11'h000) && (m <= (hs ? MPS_ISO_HS : MPS_ISO_FS));
		if (bulk)
			return hs ? (m == MPS_BULK_HS) : (m == 11'h008 || m == 11'h010
			       || m == 11'h020 || m == 11'h040);
		return m <= (hs ? MPS_INT_HS : MPS_INT_FS);
	endfunction

	// ======================================================================
	// bus decode; zero wait states, always OKAY
	wire logic       ap      = HSEL && HTRANS[1] && HREADY;
	wire logic       cmd_wr  = dp_wr_q && (dp_addr_q == A_CMD);
	wire logic       txn_wr  = dp_wr_q && (dp_addr_q == A_TXN);
	wire logic       ctrl_wr = dp_wr_q && (dp_addr_q == A_CTRL);
	wire logic       stat_wr = dp_wr_q && (dp_addr_q == A_STATUS);
	wire op_e        op      = op_e'(HWDATA[1:0]);
	wire logic [7:0] c_addr  = HWDATA[C_ADDR_LSB+7:C_ADDR_LSB];
	wire logic [7:0] c_data  = HWDATA[C_DATA_LSB+7:C_DATA_LSB];
	wire logic       idle    = (st_q == ST_IDLE);
	wire logic       is_wr   = (op == OP_WRITE);
	wire logic       bad_cfg = (c_addr == OFF_EPA_CFG) && (c_data[EPNUM_MSB:0] == 4'h0);
	wire logic       bulk    = !sh_intm_q && !sh_dir_q;
	wire logic       bad_mps = (c_addr == OFF_EPA_MPS_LO)
	                           && !legal_mps({sh_hi_q, c_data}, sh_iso_q, bulk, hs_q);
	wire logic       bad     = is_wr && (bad_cfg || bad_mps);
	wire logic       go_cmd  = cmd_wr && idle && (is_wr || op == OP_READ) && !bad;
	wire logic       go_txn  = txn_wr && idle;
	wire logic       refuse  = (cmd_wr && (!idle || bad)) || (txn_wr && !idle);
	wire logic [31:0] status = {16'h0000, rdv_q, 4'h0, refused_q, 2'(resp_q), !idle};
	wire logic [31:0] rd_mux = (HADDR[7:0] == A_STATUS) ? status :
	                           (HADDR[7:0] == A_CTRL)   ? {31'h0, hs_q} : 32'h0;

	// sequencer
	always_comb
	begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		wr_d    = 1'b0;
		rd_d    = 1'b0;
		start_d = 1'b0;
		end_d   = 1'b0;
		case (st_q)
			ST_IDLE:
			begin
				if (go_cmd)
				begin
					wr_d = is_wr;
					rd_d = !is_wr;
					st_d = is_wr ? ST_DONE : ST_RD;
				end
				else if (go_txn)
				begin
					start_d = 1'b1;
					cnt_d   = 8'(TXN_CYCLES - 1);
					st_d    = ST_TXN;
				end
			end
			ST_RD:    st_d = ST_RDCAP;
			ST_RDCAP: st_d = ST_IDLE;
			ST_TXN:
			begin
				if (cnt_q == 8'h00)
				begin
					end_d = 1'b1;
					st_d  = ST_DONE;
				end
				else
					cnt_d = cnt_q - 8'h01;
			end
			default:  st_d = ST_IDLE;
		endcase
	end

	// ======================================================================
	// bus side registers
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
			hs_q      <= 1'b0;
			refused_q <= 1'b0;
		end
		else
		begin
			dp_wr_q <= ap && HWRITE;
			if (ap)
				dp_addr_q <= HADDR[7:0];
			if (ap && !HWRITE)
				hrdata_q <= rd_mux;
			if (ctrl_wr)
				hs_q <= HWDATA[0];
			if (refuse)
				refused_q <= 1'b1; // a new refusal beats its clear
			else if (stat_wr && HWDATA[S_REFUSED])
				refused_q <= 1'b0;
		end
	end

	// link side registers and shadows of accepted configuration
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			st_q <= ST_IDLE;
			cnt_q <= 8'h00;
			{wr_q, rd_q, start_q, end_q} <= 4'h0;
			{addr_q, wdata_q, rdv_q} <= 24'h000000;
			kind_q <= KIND_OUT;
			{ep_q, pid_q, err_q, len_q} <= 17'h00000;
			resp_q <= RESP_NONE;
			{sh_iso_q, sh_intm_q, sh_dir_q, sh_hi_q} <= 6'h00;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			{wr_q, rd_q, start_q, end_q} <= {wr_d, rd_d, start_d, end_d};
			if (go_cmd)
				{addr_q, wdata_q} <= {c_addr, c_data};
			// the kind is cast on its own so the enum never takes raw bits
			if (go_txn)
			begin
				kind_q <= kind_e'(HWDATA[T_KIND_LSB+1:T_KIND_LSB]);
				{ep_q, pid_q, err_q, len_q} <= {HWDATA[3:0], HWDATA[T_PID], HWDATA[T_ERR],
					HWDATA[T_LEN_LSB+10:T_LEN_LSB]};
			end
			if (go_cmd && is_wr && c_addr == OFF_EPA_CFG)
				{sh_dir_q, sh_intm_q, sh_iso_q} <= c_data[B_DIR_IN:B_ISO];
			if (go_cmd && is_wr && c_addr == OFF_EPA_MPS_HI)
				sh_hi_q <= c_data[MPS_HI_MSB:0];
			if (st_q == ST_RDCAP)
				rdv_q <= LINK.reg_rdata;
			if (LINK.resp_valid)
				resp_q <= LINK.resp_code;
		end
	end

	// ======================================================================
	// outputs
	assign HRDATA         = hrdata_q;
	assign HREADYOUT      = 1'b1;
	assign HRESP          = 1'b0;
	assign LINK.reg_wr    = wr_q;
	assign LINK.reg_rd    = rd_q;
	assign LINK.reg_addr  = addr_q;
	assign LINK.reg_wdata = wdata_q;
	assign LINK.tx_start  = start_q;
	assign LINK.tx_kind   = kind_q;
	assign LINK.tx_ep     = ep_q;
	assign LINK.tx_pid    = pid_q;
	assign LINK.tx_len    = len_q;
	assign LINK.tx_end    = end_q;
	assign LINK.tx_err    = err_q;

endmodule

// *** verif/usb_ep_monitor.sv ***
`timescale 1ns/10ps
// ====================
// link watcher: shadows the control endpoint OUT state from link traffic
module usb_ep_monitor import usb_ep_pkg::*; (
	// clock and reset
	input  wire logic       CLK,
	input  wire logic       RST_B,
	// register port
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata,
	// transactions
	input  wire logic       tx_start,
	input  wire kind_e      tx_kind,
	input  wire logic [3:0] tx_ep,
	input  wire logic       tx_pid,
	input  wire logic       tx_end,
	input  wire logic       tx_err,
	input  wire logic       resp_valid,
	input  wire resp_e      resp_code
);
	logic setup_q, stall_q, nak_q, tog_q, auto_q;
	// decoded events; the answer code still holds at tx_end
	wire wr_ctl   = reg_wr && reg_addr == OFF_EP0_OUT_CTRL;
	wire rd_ctl   = reg_rd && reg_addr == OFF_EP0_OUT_CTRL;
	wire ep0      = tx_ep == 4'h0;
	wire good     = tx_end && ep0 && !tx_err && resp_code == RESP_ACK;
	wire set_done = good && tx_kind == KIND_SETUP;
	wire out_ok   = good && tx_kind == KIND_OUT && tx_pid == tog_q;
	wire clr_flag = reg_wr && reg_addr == OFF_DEV_EVENT && reg_wdata[0];
	wire ep0_out  = tx_start && ep0 && (tx_kind == KIND_OUT || tx_kind == KIND_PING);
	// shadow state; writes never overlap a transaction, so no deferral is kept
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			{setup_q, stall_q, nak_q, tog_q, auto_q} <= 5'h00;
		else
		begin
			setup_q <= set_done | (setup_q & ~clr_flag);
			stall_q <= set_done ? 1'b0 : wr_ctl ? reg_wdata[0] & ~setup_q : stall_q;
			nak_q   <= set_done | (out_ok & auto_q) | (wr_ctl ? reg_wdata[1] | setup_q : nak_q);
			tog_q   <= (wr_ctl && reg_wdata[2]) ? 1'b0 : (wr_ctl && reg_wdata[3]) ? 1'b1 :
				set_done ? 1'b1 : out_ok ? ~tog_q : tog_q;
			auto_q  <= wr_ctl ? reg_wdata[7] : auto_q;
		end
	end
	// ====================
	// properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_ans(resp_e c);
		resp_valid && resp_code == c;
	endsequence
	chk_resp_pulse: assert property (tx_start |=> resp_valid ##1 !resp_valid)
		else $error("answer pulse wrong");
	chk_stall_first: assert property (ep0_out && stall_q |=> s_ans(RESP_STALL))
		else $error("stall answer missing");
	chk_nak_hold: assert property (ep0_out && !stall_q && nak_q |=> s_ans(RESP_NAK))
		else $error("nak answer missing");
	chk_plain_ack: assert property (ep0_out && !stall_q && !nak_q |=> s_ans(RESP_ACK))
		else $error("ack answer missing");
	chk_setup_ack: assert property (tx_start && ep0 && tx_kind == KIND_SETUP |=> s_ans(RESP_ACK))
		else $error("setup not acked");
	chk_toggle_read: assert property (rd_ctl |=> reg_rdata[4] == $past(tog_q))
		else $error("toggle readback wrong");
	chk_nak_read: assert property (rd_ctl |=> reg_rdata[1] == $past(nak_q))
		else $error("nak readback wrong");
	chk_stall_read: assert property (rd_ctl |=> reg_rdata[0] == $past(stall_q))
		else $error("stall readback wrong");
	chk_flag_read: assert property (reg_rd && reg_addr == OFF_DEV_EVENT
		|=> reg_rdata[0] == $past(setup_q))
		else $error("setup flag readback wrong");
endmodule

// *** verif/usb_device_endpoint_control_tb.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %h want %h", $time, a, b); end end
module usb_device_endpoint_control_tb import usb_ep_pkg::*;;
	// ====================
	// bench signals
	logic        CLK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, HREADYOUT, HRESP;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, st, seed = 32'd93170;
	logic [1:0]  HTRANS = 0;
	logic [2:0]  HSIZE = 3'h2;
	logic        tog_o, setup_o, dir_o, epa_tog, tg, nk, sl, su, au;
	logic [10:0] mps_o;
	int          miscompares = 0, cmp_count = 0;
	usb_ep_if link();
	usb_ep_device usb_ep_device_inst (.CLK(CLK), .RST_B(RST_B), .LINK(link),
		.EP0_OUT_TOGGLE(tog_o), .SETUP_RECEIVED(setup_o), .EPA_MAX_PACKET(mps_o),
		.EPA_DIR_IN(dir_o), .EPA_TOGGLE(epa_tog));
	usb_ep_controller #(.TXN_CYCLES(1)) usb_ep_controller_inst (.CLK(CLK), .RST_B(RST_B),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .LINK(link));
	usb_ep_monitor usb_ep_monitor_inst (.CLK(CLK), .RST_B(RST_B), .reg_wr(link.reg_wr),
		.reg_rd(link.reg_rd), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .tx_start(link.tx_start), .tx_kind(link.tx_kind),
		.tx_ep(link.tx_ep), .tx_pid(link.tx_pid), .tx_end(link.tx_end), .tx_err(link.tx_err),
		.resp_valid(link.resp_valid), .resp_code(link.resp_code));
	// 20 MHz clock
	always #25 CLK = ~CLK;
	// ====================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction
	// expected control endpoint answer from the bench shadow state
	function automatic resp_e exp_resp(input kind_e k);
		return k == KIND_SETUP ? RESP_ACK : k == KIND_IN ? RESP_NONE :
			sl ? RESP_STALL : nk ? RESP_NAK : RESP_ACK;
	endfunction
	// one single AHB-Lite word transfer; read data lands in st
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1; HADDR <= {24'h0, a}; HTRANS <= 2'b10; HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'b00; HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		st = HRDATA;
		`CHK(HRESP, 1'b0)
	endtask
	// issue an order, then poll until the link is idle; watchdog bounds the wait
	task automatic cmd(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
		do ahb(1'b0, A_STATUS, 32'h0); while (st[0] !== 1'b0);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard: the run needs well under 40000 cycles
	initial
	begin
		#2000000;
		miscompares++;
		finish_test();
	end
	// ====================
	// main sequence
	initial
	begin : main
		logic [7:0]  d, cf[4];
		logic [10:0] mp[4];
		kind_e       k, kd[4];
		resp_e       rs[4];
		cf = '{8'h03, 8'h46, 8'hA5, 8'hC2};
		mp = '{11'h040, 11'h020, 11'h400, 11'h03F};
		kd = '{KIND_PING, KIND_PING, KIND_IN, KIND_IN};
		rs = '{RESP_ACK, RESP_NONE, RESP_NONE, RESP_NONE};
		{tg, nk, sl, su, au} = 5'h00;
		repeat (20) @(posedge CLK);
		RST_B <= 1'b1;
		foreach (cf[i])
		begin
			cmd(A_CMD, {16'h0, 8'hF3 + 8'(i + (i > 0 ? 4 : 0)), 8'h02});
			`CHK(st[15:8], 8'h00)
		end
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(st, 32'h0)
		$display("reset values done");
		// refused orders: endpoint number zero, then an illegal full-speed bulk size
		cmd(A_CMD, {8'h0, 8'h00, OFF_EPA_CFG, 8'h01});
		`CHK(st[3], 1'b1)
		ahb(1'b1, A_STATUS, 32'h8);
		cmd(A_CMD, {8'h0, 8'h30, OFF_EPA_MPS_LO, 8'h01});
		`CHK(st[3], 1'b1)
		`CHK(mps_o, 11'h000)
		ahb(1'b1, A_STATUS, 32'h8);
		cmd(A_CMD, {16'h0, OFF_EPA_CFG, 8'h02});
		`CHK(st[15:0], 16'h0000)
		$display("refusals done");
		// corner writes first (one, zero-wins, both holds), then random traffic
		for (int i = 0; i < 60; i++)
		begin
			seed = lfsr(seed);
			d = i < 3 ? (i == 0 ? 8'h08 : i == 1 ? 8'h0C : 8'h83) : seed[15:8];
			if (i < 3 || seed[1:0] == 2'd0)
			begin
				cmd(A_CMD, {8'h0, d, OFF_EP0_OUT_CTRL, 8'h01});
				au = d[7]; tg = d[2] ? 1'b0 : d[3] ? 1'b1 : tg;
				nk = d[1] | (su & nk); sl = d[0] & ~su;
			end
			else if (seed[1:0] == 2'd1)
			begin
				cmd(A_CMD, {8'h0, 8'h01, OFF_DEV_EVENT, 8'h01});
				su = 1'b0;
			end
			else
			begin
				k = kind_e'(seed[5:4]);
				cmd(A_TXN, {24'h0, seed[7] & seed[8], seed[6], k, 4'h0});
				`CHK(st[2:1], exp_resp(k))
				if (!(seed[7] & seed[8]) && exp_resp(k) == RESP_ACK && k == KIND_SETUP)
					{su, tg, nk, sl} = 4'b1110;
				else if (!(seed[7] & seed[8]) && exp_resp(k) == RESP_ACK && k == KIND_OUT
					&& seed[6] == tg)
					{tg, nk} = {~tg, nk | au};
			end
			cmd(A_CMD, {16'h0, OFF_EP0_OUT_CTRL, 8'h02});
			`CHK(st[15:8], {au, 2'b00, tg, 2'b00, nk, sl})
			`CHK(tog_o, tg)
			`CHK(setup_o, su)
		end
		$display("control endpoint done");
		// endpoint A modes: bulk OUT, interrupt OUT, iso IN at high speed, always-toggle IN
		foreach (cf[j])
		begin
			ahb(1'b1, A_CTRL, {31'h0, j == 2});
			cmd(A_CMD, {8'h0, cf[j], OFF_EPA_CFG, 8'h01});
			cmd(A_CMD, {8'h0, 5'h00, mp[j][10:8], OFF_EPA_MPS_HI, 8'h01});
			cmd(A_CMD, {8'h0, mp[j][7:0], OFF_EPA_MPS_LO, 8'h01});
			`CHK(mps_o, mp[j])
			`CHK(dir_o, cf[j][7])
			cmd(A_CMD, {16'h0, OFF_EPA_CFG, 8'h02});
			`CHK(st[15:8], cf[j])
			for (int r = 0; r < 2; r++)
			begin
				cmd(A_TXN, {24'h0, 1'b1, 1'b0, kd[j], cf[j][3:0]});
				if (j < 3)
					`CHK(st[2:1], rs[j])
				`CHK(epa_tog, j == 3 && r == 0)
			end
		end
		$display("endpoint A done");
		finish_test();
	end
endmodule
